// >>> inc/ocsd_map.svh
// register offsets, field positions, reset values and fixed counts of the stall detect block
`ifndef OCSD_MAP_SVH
`define OCSD_MAP_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define OCSD_ADDR_CTRL 8'h00
`define OCSD_ADDR_CHOP 8'h04
`define OCSD_ADDR_VMIN 8'h08
`define OCSD_ADDR_VTHR 8'h0C
`define OCSD_ADDR_DCFG 8'h10
`define OCSD_ADDR_VNOW 8'h14
`define OCSD_ADDR_STAT 8'h18
`define OCSD_ADDR_LOAD 8'h1C
`define OCSD_ADDR_XPOS 8'h20

// ************************************************************
// field positions
// ************************************************************
`define OCSD_CTRL_STOP 0
`define OCSD_CTRL_VHFS 1
`define OCSD_CTRL_VHCHM 2
`define OCSD_CTRL_QUIET 3
`define OCSD_CHOP_OFFT_LO 0
`define OCSD_CHOP_BLANK_LO 4
`define OCSD_DCFG_SG_LO 16
`define OCSD_STAT_STOP 0
`define OCSD_STAT_STALL 1
`define OCSD_STAT_ACTIVE 2
`define OCSD_STAT_PEND 3

// ************************************************************
// reset values and fixed figures
// ************************************************************
`define OCSD_RST_CTRL 4'h0
`define OCSD_RST_OFFT 4'h3
`define OCSD_RST_BLANK 2'h0
`define OCSD_RST_VMIN 23'h000000
`define OCSD_RST_VTHR 23'h000000
`define OCSD_RST_DCTIME 10'h000
`define OCSD_RST_DCSG 8'h00
`define OCSD_OFFT_CAP 4'h8
`define OCSD_LOAD_MAX 9'h1FF

`endif

// >>> inc/ocsd_pkg.sv
// types shared by the stall detect block
package ocsd_pkg;

  // load measurement window sequencer
  typedef enum logic [0:0] {
    OCSD_MEAS_IDLE = 1'b0,
    OCSD_MEAS_RUN = 1'b1
  } ocsd_meas_type;

endpackage : ocsd_pkg

// >>> design/ocsd_load_meter.sv
// load measurement window: times coil settling after each step against the reference width
`timescale 1ns/1ps
`default_nettype none
`include "ocsd_map.svh"

module ocsd_load_meter (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic start,
  input wire logic settled,
  input wire logic [9:0] window,
  // results
  output logic [8:0] load_value,
  output logic done,
  output logic ready
);
  import ocsd_pkg::*;

  ocsd_meas_type state_q, state_d;
  logic [9:0] cnt_q, cnt_d;
  logic [8:0] load_q, load_d;
  logic done_q, done_d;
  logic ready_q, ready_d;
  logic [9:0] margin;

  // what is left of the window when the coil settles is the load figure
  assign margin = window - cnt_q;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    load_d = load_q;
    done_d = 1'b0;
    ready_d = ready_q;
    case (state_q)
      OCSD_MEAS_IDLE: begin
        if (start) begin
          state_d = OCSD_MEAS_RUN;
          cnt_d = 10'h000;
        end
      end
      OCSD_MEAS_RUN: begin
        if (settled || cnt_q >= window) begin
          state_d = OCSD_MEAS_IDLE;
          done_d = 1'b1;
          ready_d = settled;
          // wide windows are clipped so the figure stays in its 9-bit range
          load_d = (margin > {1'b0, `OCSD_LOAD_MAX}) ? `OCSD_LOAD_MAX : margin[8:0]; // R4 R11
        end else begin
          cnt_d = cnt_q + 10'h001;
        end
      end
      default: state_d = OCSD_MEAS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= OCSD_MEAS_IDLE;
      cnt_q <= 10'h000;
      load_q <= 9'h000;
      done_q <= 1'b0;
      ready_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      load_q <= load_d;
      done_q <= done_d;
      ready_q <= ready_d;
    end
  end

  assign load_value = load_q;
  assign done = done_q;
  assign ready = ready_q;

endmodule : ocsd_load_meter
`default_nettype wire

// >>> design/ocsd_top.sv
// overload commutation mode: step timing, stall detection, stop on stall and apb registers
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ocsd_map.svh"

// ************************************************************
// How it works
// R1: with stop on stall set, a stall forces the commanded ramp velocity to zero.
// R2: the stop holds until software reads the ramp status register.
// R3: the stall stop event bit shows while the stall stop is active.
// R4: the load value stays readable, normally 0..255, at most 511.
// R5: software sets both high velocity flags; above minimum velocity we run full steps.
// R6: off time 2..15 accepted; 8 and above behave as 8.
// R7: below the minimum commutation velocity the motor runs normal microsteps.
// R8: in commutation mode stepping never falls below the minimum commutation velocity; here the minimum rate timer macc only starts once a step is pending.
// R9: minimum velocity ranges 0..2^22; zero disables commutation mode.
// R10: enabling the quiet voltage chopper disables commutation mode.
// R11: the 10-bit reference pulse width sets the load measurement window.
// R12: software keeps the reference width above blank time plus 1..100 cycles.
// R13: the 8-bit stall sensitivity detects stalls more readily as it grows.
// R14: software sets sensitivity slightly above reference width over 16.
// R15: software sets the load measure threshold above minimum velocity to enable stalls.
// R16: reported velocity is the ramp command, untouched by overload slowdown.
// R17: host derives real velocity from two position reads over elapsed time.
// R18: host timestamps position reads at the rising chip select edge.
// ************************************************************

module ocsd_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // ramp generator
  input wire logic [22:0] ramp_target_velocity,
  input wire logic ramp_direction,
  output logic [22:0] ramp_velocity_cmd,
  // power stage
  input wire logic coil_settled,
  output logic step_pulse,
  output logic step_dir,
  output logic full_step_mode,
  output logic [3:0] chopper_off_time
);
  import ocsd_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************
  // one phase accumulator step; the carry out is a step due
  function automatic logic [24:0] ocsd_acc_add(input logic [23:0] acc, input logic [22:0] vel);
    ocsd_acc_add = {1'b0, acc} + {2'b00, vel};
  endfunction : ocsd_acc_add

  // ************************************************************
  // declarations
  // ************************************************************
  logic [3:0] ctrl_q, ctrl_d;
  logic [3:0] off_time_q, off_time_d;
  logic [1:0] blank_sel_q, blank_sel_d;
  logic [22:0] vmin_q, vmin_d;
  logic [22:0] vthr_q, vthr_d;
  logic [9:0] dctime_q, dctime_d;
  logic [7:0] dcsg_q, dcsg_d;
  logic [31:0] prdata_q, prdata_d;
  logic stop_q, stop_d;
  logic stall_q, stall_d;
  logic [31:0] pos_q, pos_d;
  logic [23:0] acc_q, acc_d;
  logic [23:0] macc_q, macc_d;
  logic pend_q, pend_d;
  logic step_q, step_d;
  logic dir_q, dir_d;
  logic full_q, full_d;
  logic [22:0] vcmd_q, vcmd_d;
  logic [3:0] off_eff_q, off_eff_d;
  logic settle_s1_q, settle_s2_q;

  logic setup_ph, wr_acc, rd_acc, addr_ok;
  logic [22:0] vel_src;
  logic comm_en, comm_active, stall_en;
  logic [24:0] acc_sum, macc_sum;
  logic fire;
  logic [8:0] load_value;
  logic meas_done, meas_ready;

  // ************************************************************
  // apb decode
  // ************************************************************
  // zero wait state: every access completes in its first access cycle
  assign pready = 1'b1;
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  always_comb begin
    if (paddr == `OCSD_ADDR_CTRL) begin
      addr_ok = 1'b1;
    end else if (paddr == `OCSD_ADDR_CHOP) begin
      addr_ok = 1'b1;
    end else if (paddr == `OCSD_ADDR_VMIN) begin
      addr_ok = 1'b1;
    end else if (paddr == `OCSD_ADDR_VTHR) begin
      addr_ok = 1'b1;
    end else if (paddr == `OCSD_ADDR_DCFG) begin
      addr_ok = 1'b1;
    end else if (paddr == `OCSD_ADDR_VNOW) begin
      addr_ok = 1'b1;
    end else if (paddr == `OCSD_ADDR_STAT) begin
      addr_ok = 1'b1;
    end else if (paddr == `OCSD_ADDR_LOAD) begin
      addr_ok = 1'b1;
    end else if (paddr == `OCSD_ADDR_XPOS) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  assign pslverr = psel && penable && !addr_ok;

  // ************************************************************
  // configuration writes and read data capture
  // ************************************************************
  always_comb begin
    ctrl_d = ctrl_q;
    off_time_d = off_time_q;
    blank_sel_d = blank_sel_q;
    vmin_d = vmin_q;
    vthr_d = vthr_q;
    dctime_d = dctime_q;
    dcsg_d = dcsg_q;
    prdata_d = prdata_q;
    if (wr_acc) begin
      if (paddr == `OCSD_ADDR_CTRL) begin
        ctrl_d = pwdata[3:0];
      end else if (paddr == `OCSD_ADDR_CHOP) begin
        off_time_d = pwdata[`OCSD_CHOP_OFFT_LO +: 4];
        blank_sel_d = pwdata[`OCSD_CHOP_BLANK_LO +: 2];
      end else if (paddr == `OCSD_ADDR_VMIN) begin
        // values above 2^22 in the 23-bit field are clamped to 2^22
        vmin_d = (pwdata[22:0] > 23'h400000) ? 23'h400000 : pwdata[22:0]; // R9
      end else if (paddr == `OCSD_ADDR_VTHR) begin
        vthr_d = (pwdata[22:0] > 23'h400000) ? 23'h400000 : pwdata[22:0];
      end else if (paddr == `OCSD_ADDR_DCFG) begin
        dctime_d = pwdata[9:0]; // R11
        dcsg_d = pwdata[`OCSD_DCFG_SG_LO +: 8]; // R13
      end
    end
    // read data is sampled in the setup cycle so it is stable from a flip-flop
    if (setup_ph && !pwrite) begin
      if (paddr == `OCSD_ADDR_CTRL) begin
        prdata_d = {28'h0000000, ctrl_q};
      end else if (paddr == `OCSD_ADDR_CHOP) begin
        prdata_d = {26'h0, blank_sel_q, off_time_q};
      end else if (paddr == `OCSD_ADDR_VMIN) begin
        prdata_d = {9'h000, vmin_q};
      end else if (paddr == `OCSD_ADDR_VTHR) begin
        prdata_d = {9'h000, vthr_q};
      end else if (paddr == `OCSD_ADDR_DCFG) begin
        prdata_d = {8'h00, dcsg_q, 6'h00, dctime_q};
      end else if (paddr == `OCSD_ADDR_VNOW) begin
        prdata_d = {9'h000, vcmd_q}; // R16
      end else if (paddr == `OCSD_ADDR_STAT) begin
        prdata_d = {28'h0000000, pend_q, comm_active, stall_q, stop_q}; // R3
      end else if (paddr == `OCSD_ADDR_LOAD) begin
        prdata_d = {23'h000000, load_value}; // R4
      end else if (paddr == `OCSD_ADDR_XPOS) begin
        prdata_d = pos_q;
      end else begin
        prdata_d = 32'h00000000;
      end
    end
  end

  assign prdata = prdata_q;

  // ************************************************************
  // mode selection
  // ************************************************************
  // the ramp sees zero while the stall stop holds
  assign vel_src = stop_q ? 23'h000000 : ramp_target_velocity; // R1
  assign comm_en = (vmin_q != 23'h000000) && !ctrl_q[`OCSD_CTRL_QUIET] // R9 R10
                   && ctrl_q[`OCSD_CTRL_VHFS] && ctrl_q[`OCSD_CTRL_VHCHM];
  assign comm_active = comm_en && (vcmd_q >= vmin_q) && (vcmd_q != 23'h000000); // R7
  // stall checks only once the load threshold sits above the minimum velocity
  assign stall_en = vthr_q > vmin_q;

  // ************************************************************
  // step timing
  // ************************************************************
  assign acc_sum = ocsd_acc_add(acc_q, vcmd_q);
  assign macc_sum = ocsd_acc_add(macc_q, vmin_q);

  always_comb begin
    acc_d = acc_sum[23:0];
    macc_d = macc_q;
    pend_d = pend_q;
    fire = 1'b0;
    if (!comm_active) begin
      // plain microstepping follows the command directly
      fire = acc_sum[24]; // R7
      pend_d = 1'b0;
      macc_d = 24'h000000;
    end else begin
      if (acc_sum[24] || pend_q) begin
        // a step right behind the last one would merge into one long pulse
        if ((meas_ready || macc_sum[24]) && !step_q) begin
          fire = 1'b1; // R8
          pend_d = 1'b0;
          macc_d = 24'h000000;
        end else begin
          // overload: hold the step, the minimum rate keeps a blocked rotor moving
          pend_d = 1'b1;
          macc_d = macc_sum[23:0];
        end
      end else begin
        macc_d = 24'h000000;
      end
    end
  end

  always_comb begin
    step_d = fire;
    dir_d = ramp_direction;
    full_d = comm_active; // R5
    vcmd_d = vel_src; // R16
    off_eff_d = (off_time_q > `OCSD_OFFT_CAP) ? `OCSD_OFFT_CAP : off_time_q; // R6
    pos_d = pos_q;
    if (fire) begin
      pos_d = ramp_direction ? pos_q - 32'h00000001 : pos_q + 32'h00000001;
    end
  end

  // ************************************************************
  // stall detection and stop
  // ************************************************************
  always_comb begin
    stall_d = stall_q;
    stop_d = stop_q;
    if (meas_done && comm_active) begin
      stall_d = stall_en && (load_value < {1'b0, dcsg_q}); // R13
    end
    // a status read releases the stop only if it reported it
    if (rd_acc && paddr == `OCSD_ADDR_STAT && prdata_q[`OCSD_STAT_STOP]) begin
      stop_d = 1'b0; // R2
    end
    // a new stall in the clearing cycle wins
    if (meas_done && comm_active && stall_en && (load_value < {1'b0, dcsg_q})
        && ctrl_q[`OCSD_CTRL_STOP]) begin
      stop_d = 1'b1; // R1 R3
    end
  end

  // ************************************************************
  // load measurement
  // ************************************************************
  ocsd_load_meter u_meter (
    .pclk(pclk),
    .presetn(presetn),
    .start(step_q),
    .settled(settle_s2_q),
    .window(dctime_q),
    .load_value(load_value),
    .done(meas_done),
    .ready(meas_ready)
  );

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_s1_q <= 1'b0;
      settle_s2_q <= 1'b0;
    end else begin
      settle_s1_q <= coil_settled;
      settle_s2_q <= settle_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `OCSD_RST_CTRL;
      off_time_q <= `OCSD_RST_OFFT;
      blank_sel_q <= `OCSD_RST_BLANK;
      vmin_q <= `OCSD_RST_VMIN;
      vthr_q <= `OCSD_RST_VTHR;
      dctime_q <= `OCSD_RST_DCTIME;
      dcsg_q <= `OCSD_RST_DCSG;
      prdata_q <= 32'h00000000;
    end else begin
      ctrl_q <= ctrl_d;
      off_time_q <= off_time_d;
      blank_sel_q <= blank_sel_d;
      vmin_q <= vmin_d;
      vthr_q <= vthr_d;
      dctime_q <= dctime_d;
      dcsg_q <= dcsg_d;
      prdata_q <= prdata_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_q <= 1'b0;
      stall_q <= 1'b0;
      pos_q <= 32'h00000000;
      acc_q <= 24'h000000;
      macc_q <= 24'h000000;
      pend_q <= 1'b0;
      step_q <= 1'b0;
      dir_q <= 1'b0;
      full_q <= 1'b0;
      vcmd_q <= 23'h000000;
      off_eff_q <= `OCSD_RST_OFFT;
    end else begin
      stop_q <= stop_d;
      stall_q <= stall_d;
      pos_q <= pos_d;
      acc_q <= acc_d;
      macc_q <= macc_d;
      pend_q <= pend_d;
      step_q <= step_d;
      dir_q <= dir_d;
      full_q <= full_d;
      vcmd_q <= vcmd_d;
      off_eff_q <= off_eff_d;
    end
  end

  assign ramp_velocity_cmd = vcmd_q;
  assign step_pulse = step_q;
  assign step_dir = dir_q;
  assign full_step_mode = full_q;
  assign chopper_off_time = off_eff_q;

endmodule : ocsd_top
`default_nettype wire

// >>> test/ocsd_motor_model.sv
// motor and power stage model for the stall detect bench
`timescale 1ns/1ps
`default_nettype none
module ocsd_motor_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // drive side
  input wire logic step_pulse,
  input wire logic blocked,
  input wire logic [7:0] settle_cycles,
  output logic coil_settled
);
  logic [7:0] wait_q;
  // a blocked rotor never reaches the next pole, so its current never settles
  assign coil_settled = !blocked && (wait_q == 8'h00);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 8'h00;
    end else if (step_pulse) begin
      wait_q <= settle_cycles;
    end else if (wait_q != 8'h00) begin
      wait_q <= wait_q - 8'h01;
    end
  end
endmodule : ocsd_motor_model
`default_nettype wire

// >>> test/ocsd_top_properties.sv
// port level checks of the stall detect block
`timescale 1ns/1ps
`default_nettype none
module ocsd_top_properties (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // ramp and power stage
  input wire logic [22:0] ramp_target_velocity,
  input wire logic ramp_direction,
  input wire logic [22:0] ramp_velocity_cmd,
  input wire logic coil_settled,
  input wire logic step_pulse,
  input wire logic step_dir,
  input wire logic full_step_mode,
  input wire logic [3:0] chopper_off_time
);
  // ****
  // properties
  // ****
  logic bad_addr;
  assign bad_addr = (paddr[1:0] != 2'h0) || (paddr > 8'h20);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_stat_setup;
    psel && !penable && !pwrite && paddr == 8'h18 && !$past(psel && penable);
  endsequence
  sequence s_stat_report;
    psel && penable && !pwrite && paddr == 8'h18 && prdata[0];
  endsequence
  sequence s_stopped;
    ramp_velocity_cmd == 23'h0 && $past(ramp_target_velocity) != 23'h0;
  endsequence
  chk_pready_high: assert property (s_access |-> pready)
    else $error("pready low in access");
  chk_err_decode: assert property (s_access |-> pslverr == bad_addr)
    else $error("pslverr wrong");
  chk_cmd_source: assert property (
    ramp_velocity_cmd != 23'h0 |-> ramp_velocity_cmd == $past(ramp_target_velocity))
    else $error("velocity command not the target");
  chk_stop_flag: assert property (s_stat_setup ##0 s_stopped |=> prdata[0])
    else $error("stop event not reported");
  chk_flag_means_stop: assert property (
    s_access ##0 (!pwrite && paddr == 8'h18 && prdata[0]) |-> ramp_velocity_cmd == 23'h0)
    else $error("stop reported but motor runs");
  chk_off_cap: assert property (
    s_access ##0 (pwrite && paddr == 8'h04) |-> ##2 chopper_off_time ==
    (($past(pwdata[3:0], 2) > 4'h8) ? 4'h8 : $past(pwdata[3:0], 2)))
    else $error("off time not capped");
  chk_step_single: assert property (step_pulse |=> !step_pulse)
    else $error("step pulse too long");
  chk_dir_copy: assert property ($past(presetn) |-> step_dir == $past(ramp_direction))
    else $error("step direction wrong");
  chk_fsm_moving: assert property (
    full_step_mode |-> ramp_velocity_cmd != 23'h0 || $past(ramp_velocity_cmd) != 23'h0)
    else $error("full step at standstill");
  chk_prdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data changed");
  chk_stop_release: assert property (
    s_stat_report |=> ##1 ramp_velocity_cmd == $past(ramp_target_velocity))
    else $error("stop not released by status read");
endmodule : ocsd_top_properties
bind ocsd_top ocsd_top_properties u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ramp_target_velocity(ramp_target_velocity),
  .ramp_direction(ramp_direction), .ramp_velocity_cmd(ramp_velocity_cmd),
  .coil_settled(coil_settled), .step_pulse(step_pulse), .step_dir(step_dir),
  .full_step_mode(full_step_mode), .chopper_off_time(chopper_off_time));
`default_nettype wire

// >>> test/ocsd_top_tb.sv
// self-checking bench of the stall detect block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
`define WAITC(c) begin int w; w = 0; while (!(c) && w < 20000) begin \
  @(posedge pclk); w++; end if (!(c)) begin errors++; tally_and_finish; end end
module ocsd_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dir, blocked, coil;
  logic step_pulse, step_dir, fsm;
  logic [7:0] paddr, settle;
  logic [31:0] pwdata, prdata, seed, r;
  logic [22:0] tgt, cmd;
  logic [3:0] off_now;
  logic [31:0] exp_q[$], msk_q[$];
  logic [3:0] off_tab[4] = '{4'h2, 4'h7, 4'h8, 4'hF};
  logic [39:0] rst_tab[7] = '{{8'h00, 32'h0}, {8'h04, 32'h3}, {8'h08, 32'h0},
    {8'h0C, 32'h0}, {8'h10, 32'h0}, {8'h20, 32'h0}, {8'h24, 32'h0}};
  int errors, n_checks, pos, steps;
  ocsd_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ramp_target_velocity(tgt), .ramp_direction(dir),
    .ramp_velocity_cmd(cmd), .coil_settled(coil), .step_pulse(step_pulse),
    .step_dir(step_dir), .full_step_mode(fsm), .chopper_off_time(off_now));
  ocsd_motor_model motor (.pclk(pclk), .presetn(presetn), .step_pulse(step_pulse),
    .blocked(blocked), .settle_cycles(settle), .coil_settled(coil));
  // ****
  // helpers
  // ****
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  // expected read data is queued at setup and judged by the monitor at completion
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) begin
      exp_q.push_back(d);
      msk_q.push_back(m);
    end
    @(posedge pclk);
    penable <= 1'b1;
    `WAITC(psel && penable && pready)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  always @(posedge pclk) begin
    if (step_pulse) begin
      pos = step_dir ? pos - 1 : pos + 1;
      steps++;
    end
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      `CHK(prdata & msk_q[0], exp_q[0] & msk_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    errors++;
    tally_and_finish;
  end
  // ****
  // scenarios
  // ****
  initial begin
    {presetn, psel, penable, pwrite, dir, blocked} = 6'h0;
    {paddr, pwdata, tgt} = '0;
    settle = 8'h10;
    seed = 32'd89492;
    {errors, n_checks, pos, steps} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_tab[i]) apb(1'b0, rst_tab[i][39:32], rst_tab[i][31:0], '1);
    apb(1'b1, 8'h08, 32'h00FFFFFF, '0);
    apb(1'b0, 8'h08, 32'h00400000, '1);
    foreach (off_tab[i]) begin
      apb(1'b1, 8'h04, {26'h0, 2'(i), off_tab[i]}, '0);
      apb(1'b0, 8'h04, {26'h0, 2'(i), off_tab[i]}, '1);
      repeat (3) @(posedge pclk);
      `CHK(off_now, (off_tab[i] > 4'h8) ? 4'h8 : off_tab[i])
    end
    repeat (3) begin
      r = xs() & 32'h00FF03FF;
      apb(1'b1, 8'h10, r, '0);
      apb(1'b0, 8'h10, r, '1);
    end
    $display("test registers done");
    apb(1'b1, 8'h00, 32'h6, '0);
    apb(1'b1, 8'h08, 32'h00040000, '0);
    tgt <= 23'(xs() & 32'h0003FFFF);
    repeat (20) @(posedge pclk);
    `CHK(fsm, 1'b0)
    apb(1'b0, 8'h14, {9'h0, tgt}, '1);
    apb(1'b1, 8'h08, 32'h0, '0);
    tgt <= 23'h100000;
    repeat (20) @(posedge pclk);
    `CHK(fsm, 1'b0)
    apb(1'b1, 8'h08, 32'h00010000, '0);
    apb(1'b1, 8'h00, 32'hE, '0);
    repeat (20) @(posedge pclk);
    `CHK(fsm, 1'b0)
    apb(1'b1, 8'h00, 32'h6, '0);
    `WAITC(fsm === 1'b1)
    $display("test modes done");
    blocked <= 1'b1;
    dir <= 1'b1;
    tgt <= 23'h200000;
    steps = 0;
    repeat (2600) @(posedge pclk);
    `CHK(steps >= 9, 1'b1)
    apb(1'b0, 8'h14, 32'h00200000, '1);
    $display("test blocked done");
    dir <= 1'b0;
    apb(1'b1, 8'h10, 32'h000E00C8, '0);
    apb(1'b1, 8'h0C, 32'h00011000, '0);
    apb(1'b1, 8'h00, 32'h7, '0);
    `WAITC(cmd === 23'h0)
    repeat (50) @(posedge pclk);
    blocked <= 1'b0;
    apb(1'b1, 8'h10, 32'h000000C8, '0);
    apb(1'b0, 8'h1C, 32'h0, 32'h1FF);
    `CHK(cmd, 23'h0)
    apb(1'b0, 8'h18, 32'h3, 32'hF);
    `WAITC(cmd === tgt)
    apb(1'b0, 8'h18, 32'h4, 32'h5);
    $display("test stall done");
    tgt <= 23'h0;
    repeat (300) @(posedge pclk);
    apb(1'b1, 8'h14, '1, '0);
    apb(1'b0, 8'h14, 32'h0, '1);
    apb(1'b0, 8'h20, 32'(pos), '1);
    $display("test position done");
    tally_and_finish;
  end
endmodule : ocsd_top_tb
`default_nettype wire
